/* dv/sapc_monitor.sv */
// Checker for the converter link: framing, data timing, quiet gap.
// Assumes the bench instantiates it beside the 12-bit link interface.
`timescale 1ns/10ps
`default_nettype none
module sapc_monitor
  import sapc_pkg::*;
(
  input wire logic clk_sys,            // System clock
  input wire logic rstn,               // Sync reset, active low
  input wire logic frame_n,            // Frame strobe
  input wire logic sclk,               // Serial clock
  input wire logic result_out_line,    // Data value
  input wire logic result_out_line_oe  // Data drive enable
);
  logic       sclk_d_r;
  logic       frame_d_r;
  logic       sfall;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [7:0] since_r;
  logic [7:0] since_nxt;
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;

  // Raw pin view, ahead of the device's own synchroniser
  always_comb begin
    sfall     = sclk_d_r & ~sclk;
    cnt_nxt   = frame_n ? 5'h00 : cnt_r + {4'h0, sfall};
    since_nxt = (sfall | (frame_d_r & ~frame_n)) ? 8'h00 :
                (since_r == 8'hff) ? since_r : since_r + 8'h01;
    quiet_nxt = result_out_line_oe ? 8'h00 :
                (quiet_r == 8'hff) ? quiet_r : quiet_r + 8'h01;
  end

  // Saturated quiet count at reset: a frame right after reset is legal
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_d_r  <= 1'b1;
      frame_d_r <= 1'b1;
      cnt_r     <= 5'h00;
      since_r   <= 8'hff;
      quiet_r   <= 8'hff;
    end else begin
      sclk_d_r  <= sclk;
      frame_d_r <= frame_n;
      cnt_r     <= cnt_nxt;
      since_r   <= since_nxt;
      quiet_r   <= quiet_nxt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_OE_ON: assert property ($fell(frame_n)
    |-> ##[1:6] result_out_line_oe)
    else $error("data not driven after strobe fall");
  AST_ZERO_FIRST: assert property ($rose(result_out_line_oe)
    |-> !result_out_line)
    else $error("first bit not zero");
  AST_ABORT: assert property ($rose(frame_n)
    |-> ##[1:6] !result_out_line_oe)
    else $error("data still driven after strobe rise");
  AST_IDLE: assert property (frame_n [*8] |-> !result_out_line_oe)
    else $error("data driven outside frame");
  AST_HOLD15: assert property (sfall && !frame_n && cnt_r == 5'd14
    |=> result_out_line_oe [*3])
    else $error("data released before last bit");
  AST_REL16: assert property (sfall && !frame_n && cnt_r == 5'd15
    |-> ##[1:6] !result_out_line_oe)
    else $error("data not released at last fall");
  AST_SHIFT: assert property (result_out_line_oe
    && $past(result_out_line_oe) && $changed(result_out_line)
    |-> since_r <= 8'd6)
    else $error("data changed away from a serial fall");
  AST_ZEROS: assert property (result_out_line_oe
    && !frame_n && cnt_r <= 5'd3 |-> !result_out_line)
    else $error("leading bit not zero");
  AST_QUIET: assert property ($fell(frame_n)
    |-> quiet_r >= QUIET_GAP_CYC)
    else $error("quiet gap too short");

  COV_FULL: cover property (sfall && !frame_n && cnt_r == 5'd15);
  COV_SLEEP: cover property ($rose(frame_n) && cnt_r >= 5'd2 && cnt_r <= 5'd9);
  COV_GLITCH: cover property ($rose(frame_n) && cnt_r <= 5'd1);
endmodule : sapc_monitor
`default_nettype wire

/* dv/sapc_tb.sv */
// Bench: host and converter ends face each other, 12-bit and 10-bit pairs.
// Assumes package, interface, both ends and the monitor compile first.
`timescale 1ns/10ps
`default_nettype none
module sapc_tb import sapc_pkg::*;;
  logic        clk_sys;
  logic        rstn;
  logic        start;
  logic [4:0]  edges;
  logic [11:0] code_w;
  logic [9:0]  code_n;
  logic        done;
  logic        hold;
  logic        powered;
  logic        powered_n;
  logic        busy;
  logic        hold_mid;
  logic        sclk_q;
  logic [15:0] rise_word;
  logic        ready;
  logic        conv;
  logic        seen_hold;
  logic        seen_conv;
  logic [15:0] word;
  logic [15:0] word_n;
  int          bad_count;
  int          checked;

  sapc_if lnk ();
  sapc_if lnk_n ();

  // Both pairs run in lockstep from the same start
  sapc_dev #(.RES_BITS(12)) i_sapc_dev (.clk_sys(clk_sys), .rstn(rstn),
    .lnk(lnk.dev), .sample_code(code_w), .hold_r(hold),
    .powered_r(powered), .ready_r(ready), .conv_pulse_r(conv));
  sapc_host i_sapc_host (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk.host),
    .start(start), .edges(edges), .busy_r(busy), .done_r(done),
    .word_r(word));
  sapc_dev #(.RES_BITS(10)) i_sapc_dev_n (.clk_sys(clk_sys), .rstn(rstn),
    .lnk(lnk_n.dev), .sample_code(code_n), .hold_r(), .powered_r(powered_n),
    .ready_r(), .conv_pulse_r());
  sapc_host i_sapc_host_n (.clk_sys(clk_sys), .rstn(rstn),
    .lnk(lnk_n.host), .start(start), .edges(edges), .busy_r(),
    .done_r(), .word_r(word_n));
  sapc_monitor i_sapc_monitor (.clk_sys(clk_sys), .rstn(rstn),
    .frame_n(lnk.frame_n), .sclk(lnk.sclk),
    .result_out_line(lnk.result_out_line),
    .result_out_line_oe(lnk.result_out_line_oe));

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic give_verdict;
    $display("counts: checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // One frame of n falls; bounded wait on the host's done pulse
  task automatic run_frame(input logic [4:0] n);
    int i;
    seen_hold = 1'b0;
    seen_conv = 1'b0;
    hold_mid  = 1'bx;
    rise_word = 16'h0000;
    sclk_q    = 1'b1;
    @(negedge clk_sys);
    start = 1'b1;
    edges = n;
    @(negedge clk_sys);
    start = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 3000) begin
      seen_hold = seen_hold | hold;
      seen_conv = seen_conv | conv;
      // Hold level mid-frame, well before the 13th fall
      if (i == 100) begin
        hold_mid = hold;
      end
      // Bits as a slow host reading on serial clock rises sees them
      if (!lnk.frame_n && lnk.sclk && !sclk_q) begin
        rise_word = {rise_word[14:0], lnk.result_out_line};
      end
      sclk_q = lnk.sclk;
      @(negedge clk_sys);
      i++;
    end
    if (i >= 3000) begin
      bad_count++;
      $display("BAD done expected 1 seen 0");
      give_verdict();
    end
  endtask : run_frame

  // Back-to-back full frames, both signs of the code
  task automatic t_full;
    logic [11:0] tab [4] = '{12'h7ff, 12'h800, 12'h5a3, 12'hfff};
    for (int k = 0; k < 4; k++) begin
      code_w = tab[k];
      code_n = tab[k][11:2];
      run_frame(5'h10);
      cmp_word("word12", {4'h0, tab[k]}, word);
      cmp_word("rise12", {4'h0, tab[k]}, rise_word);
      cmp_bit("hold_mid", 1'b1, hold_mid);
      cmp_bit("busy", 1'b0, busy);
      cmp_word("word10", {4'h0, tab[k][11:2], 2'b00}, word_n);
      cmp_bit("conv", 1'b1, seen_conv);
      cmp_bit("hold", 1'b1, seen_hold);
      cmp_bit("track", 1'b0, hold);
      cmp_bit("powered", 1'b1, powered);
    end
    $display("test full done");
  endtask : t_full

  // Strobe length picks mode; boundaries 1, 2, 9, 10 and 12 falls
  task automatic t_modes;
    logic [4:0] ne [8] = '{5'h01, 5'h02, 5'h01, 5'h09,
                           5'h0a, 5'h09, 5'h0c, 5'h0c};
    logic       pe [8] = '{1'b1, 1'b0, 1'b0, 1'b0,
                           1'b1, 1'b0, 1'b1, 1'b1};
    for (int k = 0; k < 8; k++) begin
      run_frame(ne[k]);
      cmp_bit("powered", pe[k], powered);
      cmp_bit("powered10", pe[k], powered_n);
      if (!pe[k]) cmp_bit("ready", 1'b0, ready);
      if (ne[k] == 5'h0a) begin
        cmp_bit("ready", 1'b1, ready);
        cmp_bit("track", 1'b0, hold);
        cmp_bit("wake_track", 1'b0, hold_mid);
      end
    end
    $display("test modes done");
  endtask : t_modes

  // Reset, then full frames, mode changes, and valid data after wake
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    edges = 5'h10;
    code_w = 12'h000;
    code_n = 10'h000;
    bad_count = 0;
    checked = 0;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    t_full();
    t_modes();
    t_full();
    give_verdict();
  end
endmodule : sapc_tb
`default_nettype wire

/* hdl/sapc_dev.sv */
// Converter end: frame counting, result shifting, power-state control.
// Assumes strobe and serial clock are asynchronous pins from the host.
`timescale 1ns/10ps
`default_nettype none
module sapc_dev
  import sapc_pkg::*;
#(
  parameter int RES_BITS = 12             // 12 or 10
) (
  input  wire logic                clk_sys,     // System clock
  input  wire logic                rstn,        // Sync reset, active low
  sapc_if.dev                      lnk,         // Link pins
  input  wire logic [RES_BITS-1:0] sample_code, // Two's complement sample
  output logic                     hold_r,      // Sampler in hold
  output logic                     powered_r,   // Analog powered
  output logic                     ready_r,     // Warm-up time elapsed
  output logic                     conv_pulse_r // Frame start pulse, only when already powered
);
  // Only the two result widths are served
  if (RES_BITS != 12 && RES_BITS != 10) begin : g_res_check
    $error("RES_BITS must be 10 or 12");
  end

  // Two-stage synchronisers; stage one feeds stage two only
  logic [1:0] cs_sync_r;
  logic [1:0] ck_sync_r;
  logic       cs_d_r;
  logic       ck_d_r;
  logic [1:0] cs_sync_nxt;
  logic [1:0] ck_sync_nxt;
  always_comb begin
    cs_sync_nxt = {cs_sync_r[0], lnk.frame_n};
    ck_sync_nxt = {ck_sync_r[0], lnk.sclk};
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cs_sync_r <= 2'h3;
      ck_sync_r <= 2'h3;                   // Clock idles high: no false rise
      cs_d_r    <= 1'b1;
      ck_d_r    <= 1'b1;
    end else begin
      cs_sync_r <= cs_sync_nxt;
      ck_sync_r <= ck_sync_nxt;
      cs_d_r    <= cs_sync_r[1];
      ck_d_r    <= ck_sync_r[1];
    end
  end

  logic cs_s;
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  logic ck_rise;
  assign cs_s    = cs_sync_r[1];
  assign cs_fall = cs_d_r & ~cs_s;
  assign cs_rise = ~cs_d_r & cs_s;
  assign ck_fall = ck_d_r & ~ck_sync_r[1];
  assign ck_rise = ~ck_d_r & ck_sync_r[1];

  // Frame state registers
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        in_frame_r;
  logic        in_frame_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic        dout_r;
  logic        dout_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        hold_nxt;
  logic        powered_nxt;
  logic        was_down_r;
  logic        was_down_nxt;
  logic        conv_nxt;
  logic [15:0] frame_word;

  // Zeros, then code MSB-first, narrow codes padded at the tail
  always_comb begin
    frame_word = SHIFT_RST;
    frame_word[15-LEAD_ZEROS -: RES_BITS] = sample_code;
  end

  // Frame sequencing and power decision
  always_comb begin
    cnt_nxt      = cnt_r;
    in_frame_nxt = in_frame_r;
    shift_nxt    = shift_r;
    dout_nxt     = dout_r;
    oe_nxt       = oe_r;
    hold_nxt     = hold_r;
    powered_nxt  = powered_r;
    was_down_nxt = was_down_r;
    conv_nxt     = 1'b0;
    if (cs_fall) begin
      cnt_nxt      = CNT_RST;
      in_frame_nxt = 1'b1;
      shift_nxt    = {frame_word[14:0], 1'b0};
      dout_nxt     = frame_word[15];
      oe_nxt       = 1'b1;
      hold_nxt     = 1'b1;
      conv_nxt     = powered_r;
      was_down_nxt = ~powered_r;
      powered_nxt  = 1'b1;
    end else if (cs_rise && in_frame_r) begin
      in_frame_nxt = 1'b0;
      oe_nxt       = 1'b0;
      cnt_nxt      = CNT_RST;
      if (cnt_r < 5'(FRAME_EDGES)) begin
        hold_nxt = 1'b0;                            // Abort: resume track
        if (was_down_r) begin
          powered_nxt = (cnt_r >= 5'(PWR_KEEP_EDGES));
        end else if (cnt_r >= 5'(GLITCH_EDGES) &&
                     cnt_r < 5'(PWR_KEEP_EDGES)) begin
          powered_nxt = 1'b0;
        end else begin
          powered_nxt = 1'b1;
        end
      end
    end else if (in_frame_r && !cs_s) begin
      if (ck_fall && cnt_r < 5'(FRAME_EDGES)) begin
        cnt_nxt   = cnt_r + 5'h01;
        dout_nxt  = shift_r[15];
        shift_nxt = {shift_r[14:0], 1'b0};
        if (cnt_r == 5'(FRAME_EDGES - 1)) begin
          oe_nxt = 1'b0;
        end
      end
      // Waking sampler tracks on first edge; else after 13 falls
      if (was_down_r && (ck_fall || ck_rise) &&
          cnt_r == CNT_RST) begin
        hold_nxt = 1'b0;
      end else if (ck_rise && cnt_r >= 5'(TRACK_EDGES)) begin
        hold_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r        <= CNT_RST;
      in_frame_r   <= 1'b0;
      shift_r      <= SHIFT_RST;
      dout_r       <= 1'b0;
      oe_r         <= 1'b0;
      hold_r       <= 1'b0;
      powered_r    <= 1'b1;
      was_down_r   <= 1'b0;
      conv_pulse_r <= 1'b0;
    end else begin
      cnt_r        <= cnt_nxt;
      in_frame_r   <= in_frame_nxt;
      shift_r      <= shift_nxt;
      dout_r       <= dout_nxt;
      oe_r         <= oe_nxt;
      hold_r       <= hold_nxt;
      powered_r    <= powered_nxt;
      was_down_r   <= was_down_nxt;
      conv_pulse_r <= conv_nxt;
    end
  end

  // Warm-up timer; powering down clears readiness at once
  logic [9:0] warm_r;
  logic [9:0] warm_nxt;
  logic       ready_nxt;
  always_comb begin
    warm_nxt  = warm_r;
    ready_nxt = ready_r;
    if (!powered_r) begin
      warm_nxt  = 10'h000;
      ready_nxt = 1'b0;
    end else if (warm_r < 10'(PWRUP_CYC)) begin
      warm_nxt = warm_r + 10'h001;
    end else begin
      ready_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      warm_r  <= 10'h000;
      ready_r <= 1'b0;
    end else begin
      warm_r  <= warm_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign lnk.result_out_line    = dout_r;
  assign lnk.result_out_line_oe = oe_r;
endmodule : sapc_dev
`default_nettype wire

/* hdl/sapc_host.sv */
// Host end: makes the strobe and divided serial clock, captures results.
// Assumes the data pin comes from another domain; it is synchronised.
`timescale 1ns/10ps
`default_nettype none
module sapc_host
  import sapc_pkg::*;
(
  input  wire logic        clk_sys,    // System clock
  input  wire logic        rstn,       // Sync reset, active low
  sapc_if.host             lnk,        // Link pins
  input  wire logic        start,      // Request one frame, pulse
  input  wire logic [4:0]  edges,      // Falls to run, 1..16
  output logic             busy_r,     // Frame or gap in progress
  output logic             done_r,     // Frame ended, pulse
  output logic [15:0]      word_r      // Captured frame bits
);
  logic [1:0] d_sync_r;
  logic [1:0] d_sync_nxt;
  assign d_sync_nxt = {d_sync_r[0], lnk.result_out_line};

  sapc_host_st_t st_r;
  sapc_host_st_t st_nxt;
  logic [7:0]  tmr_r;
  logic [7:0]  tmr_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic [4:0]  goal_r;
  logic [4:0]  goal_nxt;
  logic        sclk_r;
  logic        sclk_nxt;
  logic        cs_r;
  logic        cs_nxt;
  logic [15:0] word_nxt;
  logic        busy_nxt;
  logic        done_nxt;

  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = tmr_r;
    cnt_nxt  = cnt_r;
    goal_nxt = goal_r;
    sclk_nxt = sclk_r;
    cs_nxt   = cs_r;
    word_nxt = word_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    case (st_r)
      SAPC_IDLE: begin
        if (start) begin
          goal_nxt = (edges == 5'h00 || edges > 5'(FRAME_EDGES)) ?
                     5'(FRAME_EDGES) : edges;
          cs_nxt   = 1'b0;
          cnt_nxt  = CNT_RST;
          tmr_nxt  = 8'(SCLK_HALF_CYC);
          busy_nxt = 1'b1;
          st_nxt   = SAPC_HIGH;
        end
      end
      SAPC_HIGH: begin
        if (tmr_r != 8'h00) begin
          tmr_nxt = tmr_r - 8'h01;
        end else begin
          sclk_nxt = 1'b0;
          cnt_nxt  = cnt_r + 5'h01;
          // Sample the bit placed on the previous fall
          word_nxt = {word_r[14:0], d_sync_r[1]};
          tmr_nxt  = 8'(SCLK_HALF_CYC);
          st_nxt   = SAPC_LOW;
        end
      end
      SAPC_LOW: begin
        if (tmr_r != 8'h00) begin
          tmr_nxt = tmr_r - 8'h01;
        end else if (cnt_r >= goal_r) begin
          cs_nxt  = 1'b1;                       // Length sets mode
          tmr_nxt = 8'(GAP_CYC);
          st_nxt  = SAPC_GAP;
        end else begin
          sclk_nxt = 1'b1;
          tmr_nxt  = 8'(SCLK_HALF_CYC);
          st_nxt   = SAPC_HIGH;
        end
      end
      SAPC_GAP: begin
        if (tmr_r != 8'h00) begin
          tmr_nxt = tmr_r - 8'h01;
        end else begin
          sclk_nxt = 1'b1;                      // Back to idle high for next fall
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = SAPC_IDLE;
        end
      end
      default: st_nxt = SAPC_IDLE;
    endcase
  end

  // Clock idles high so the first edge seen in a frame is a fall
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      d_sync_r <= 2'h0;
      st_r     <= SAPC_IDLE;
      tmr_r    <= 8'h00;
      cnt_r    <= CNT_RST;
      goal_r   <= 5'(FRAME_EDGES);
      sclk_r   <= 1'b1;
      cs_r     <= 1'b1;
      word_r   <= SHIFT_RST;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      d_sync_r <= d_sync_nxt;
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      cnt_r    <= cnt_nxt;
      goal_r   <= goal_nxt;
      sclk_r   <= sclk_nxt;
      cs_r     <= cs_nxt;
      word_r   <= word_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
    end
  end

  assign lnk.frame_n = cs_r;
  assign lnk.sclk    = sclk_r;
endmodule : sapc_host
`default_nettype wire

/* pkg/sapc_if.sv */
// Link between converter end and host end: strobe, serial clock, data.
// The data wire keeps its last value while the enable is low.
`timescale 1ns/10ps
`default_nettype none
interface sapc_if;
  logic frame_n;        // Frame strobe, active low, host driven
  logic sclk;           // Serial clock, host driven
  logic result_out_line;    // Data value from converter
  logic result_out_line_oe; // High while converter drives data
  modport dev  (input frame_n, input sclk,
                output result_out_line, output result_out_line_oe);
  modport host (output frame_n, output sclk,
                input result_out_line, input result_out_line_oe);
endinterface : sapc_if
`default_nettype wire

/* pkg/sapc_pkg.sv */
// Shared constants for the serial converter link and its host master.
// Assumes both ends run on clk_sys at 250 MHz.
`default_nettype none
package sapc_pkg;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          FRAME_EDGES     = 16;   // Falling edges per frame
  localparam int          TRACK_EDGES     = 13;   // Hold ends after these
  localparam int          PWR_KEEP_EDGES  = 10;   // Strobe low this long
  localparam int          GLITCH_EDGES    = 2;    // Below this, no power-down
  localparam int          LEAD_ZEROS      = 4;
  localparam int          QUIET_GAP_NS    = 60;
  localparam int          ACQ_TIME_NS     = 290;
  localparam int          PWRUP_TIME_NS   = 1000;
  localparam int          QUIET_GAP_CYC   =
    (QUIET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ACQ_CYC         =
    (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PWRUP_CYC       =
    (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host gap covers quiet time and acquisition, whichever is longer
  localparam int          GAP_CYC         =
    (ACQ_CYC > QUIET_GAP_CYC) ? ACQ_CYC : QUIET_GAP_CYC;
  localparam int          SCLK_HALF_CYC   = 10;   // Host divider reload; half period is 11 cycles
  localparam logic [4:0]  CNT_RST         = 5'h00;
  localparam logic [15:0] SHIFT_RST       = 16'h0000;
  typedef enum logic [1:0] {SAPC_IDLE, SAPC_LOW, SAPC_HIGH, SAPC_GAP}
    sapc_host_st_t;
endpackage : sapc_pkg
`default_nettype wire
